// File: inc/tc_alarm_pkg.sv
package tc_alarm_pkg;

  // Alarm source identifiers; none means no alarm latched
  typedef enum logic [3:0] {
    SRC_NONE, SRC_LTC_PHASE, SRC_COLOUR_PHASE, SRC_LTC_VS_VITC, SRC_DROPOUT,
    SRC_VALIDITY, SRC_TIME_SEQ, SRC_USER_SEQ, SRC_LTC_LEVEL
  } alarm_src_t;

  localparam int NUM_COUNTED = 4;
  localparam int CNT_W       = 8;

  // BCD timecode word
  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] frames;
  } timecode_t;

  // Six code flags; slot 2 is parity for LTC, field flag for VITC
  typedef struct packed {
    logic       drop_frame;
    logic       colour_frame;
    logic       parity_field;
    logic [2:0] binary_group;
  } code_flags_t;

  // Enables per source
  typedef struct packed {
    logic ltc_phase;
    logic colour_phase;
    logic ltc_vs_vitc;
    logic dropout;
    logic validity;
    logic time_seq;
    logic user_seq;
    logic ltc_level;
  } alarm_enable_t;

  // Per-event pulses from the readers
  typedef struct packed {
    logic dropout;
    logic validity;
    logic time_seq;
    logic user_seq;
  } reader_events_t;

  // Thresholds and limits; level in tenths of a volt
  typedef struct packed {
    logic [7:0] ltc_phase_bits;
    logic [7:0] dropout_count;
    logic [7:0] validity_count;
    logic [7:0] time_seq_count;
    logic [7:0] user_seq_count;
    logic [7:0] level_min;
    logic [7:0] level_max;
  } alarm_limits_t;

  localparam logic [7:0] DEF_PHASE_BITS = 8'h01;
  localparam logic [7:0] DEF_COUNT      = 8'h01;
  localparam logic [7:0] DEF_LEVEL_MIN  = 8'h01;
  localparam logic [7:0] DEF_LEVEL_MAX  = 8'h1e;

  // Beeper cadence
  localparam int BEEP_HALF_MS     = 250;
  localparam int CLK_KHZ          = 100000;
  localparam int BEEP_HALF_CYCLES = BEEP_HALF_MS * CLK_KHZ;
  localparam int BEEP_CNT_W       = 25;

  // Frame field in BCD; highest legal value is 30
  localparam logic [7:0] FRAMES_MAX_BCD = 8'h30;

  // Serial log record kinds
  typedef enum logic [1:0] {
    LOG_ALARM, LOG_READER_CHANGE, LOG_LEARN
  } log_kind_t;

  typedef struct packed {
    log_kind_t  kind;
    alarm_src_t source;
    logic       vitc_active;
    timecode_t  last_good;
  } log_record_t;

endpackage

// File: core/threshold_counter.sv
`timescale 1ns/100ps
module threshold_counter
  import tc_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Events
  input  wire logic             event_in,
  input  wire logic             clear_in,
  input  wire logic [CNT_W-1:0] threshold_in,
  // Result
  output logic                  exceeded_out
);

  logic [CNT_W-1:0] count;

  // Saturates so a long burst of errors cannot wrap below threshold
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (clear_in) begin
      count <= '0; // (RULE21)
    end else if (event_in && count != {CNT_W{1'b1}}) begin
      count <= count + 1'b1;
    end
  end

  assign exceeded_out = (count > threshold_in);

endmodule

// File: core/timecode_alarm_monitor.sv
// Contract
// (RULE1) Audible enabled and an enabled alarm triggers: beeper toggles on and off.
// (RULE2) Beeper keeps sounding after the cause disappears, until alarm clear.
// (RULE3) Hold identifier of the most recently triggered alarm source.
// (RULE4) Alarm clear resets latched alarms, silences beeper, clears last-alarm id; code ignores a clear in a cycle where an enabled source triggers.
// (RULE5) Serial monitor on: log alarms with last good time, and reader changes.
// (RULE6) Learn active: send a full timecode report to the serial port.
// (RULE7) Colour phase reported as index 1..4 NTSC, 1..8 PAL.
// (RULE8) Comparison value is VITC minus offset minus LTC, in timecode form.
// (RULE9) Present six code flags: drop, colour, parity/field, three binary groups.
// (RULE10) Parity shown only reading LTC; field flag only reading VITC.
// (RULE11) Report hardware, validity and sequence errors of the active reader.
// (RULE12) Each source has its own enable; counted sources hold separate thresholds.
// (RULE13) LTC phase alarm when offset in bits exceeds threshold, default one.
// (RULE14) Colour phase alarm on any colour phase mismatch with reference.
// (RULE15) LTC versus VITC alarm when VITC minus offset differs from LTC.
// (RULE16) Dropout alarm when dropout count exceeds threshold, default one.
// (RULE17) Validity alarm counts illegal values, like frames above 30, past threshold.
// (RULE18) Time sequence alarm counts bad time order, triggers past threshold.
// (RULE19) User bits sequence alarm counts bad user order, triggers past threshold.
// (RULE20) LTC level alarm below minimum or above maximum, defaults 0.1 and 3.0.
// (RULE21) Alarm clear also zeroes dropout, validity and sequence counters.
// (RULE22) Disabled source raises no new alarm; latched state stays until clear.
`timescale 1ns/100ps
module timecode_alarm_monitor
  import tc_alarm_pkg::*;
#(
  parameter int BEEP_HALF = BEEP_HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_in,
  // Decoded timecode and reader state
  input  wire tc_alarm_pkg::timecode_t      ltc_time_in,
  input  wire tc_alarm_pkg::timecode_t      vitc_time_in,
  input  wire tc_alarm_pkg::timecode_t      offset_in,
  input  wire logic                         both_assigned_in,
  input  wire logic                         vitc_active_in,
  input  wire logic                         frame_strobe_in,
  input  wire tc_alarm_pkg::code_flags_t    flags_in,
  input  wire tc_alarm_pkg::reader_events_t events_in,
  input  wire logic                         hw_error_in,
  // Measurements against reference video
  input  wire logic [7:0]                   ltc_phase_bits_in,
  input  wire logic [2:0]                   code_colour_field_in,
  input  wire logic [2:0]                   ref_colour_field_in,
  input  wire logic                         pal_in,
  input  wire logic [7:0]                   ltc_level_in,
  // Configuration
  input  wire tc_alarm_pkg::alarm_enable_t  enable_in,
  input  wire tc_alarm_pkg::alarm_limits_t  limits_in,
  input  wire logic                         audible_en_in,
  input  wire logic                         serial_monitor_en_in,
  input  wire logic                         learn_in,
  input  wire logic                         alarm_clear_key_in,
  // Alarm outputs
  output logic                              beeper_out,
  output logic                              alarm_active_out,
  output tc_alarm_pkg::alarm_src_t          last_alarm_out,
  // Overlay values
  output logic [3:0]                        colour_index_out,
  output tc_alarm_pkg::timecode_t           compare_out,
  output tc_alarm_pkg::code_flags_t         flags_out,
  output logic                              flag_parity_shown_out,
  output logic                              flag_field_shown_out,
  output logic [2:0]                        code_errors_out,
  // Serial log
  output logic                              log_valid_out,
  output tc_alarm_pkg::log_record_t         log_record_out,
  input  wire logic                         log_ready_in
);

  logic [NUM_COUNTED-1:0] counted_event;
  logic [NUM_COUNTED-1:0] counted_en;
  logic [NUM_COUNTED-1:0] exceeded;
  logic [CNT_W-1:0]       counted_thr [NUM_COUNTED];
  logic [8:0]             trig;
  logic                   latched;
  logic [BEEP_CNT_W-1:0]  beep_cnt;
  logic                   beep_phase;
  logic                   prev_vitc;
  logic                   prev_learn;
  timecode_t              last_good;
  timecode_t              vitc_less_off;
  timecode_t              next_compare;
  alarm_src_t             next_src;
  logic                   frames_bad;

  // BCD subtraction over h:m:s:f; frames wrap at 30 as a plain counter
  function automatic logic [7:0] bcd_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic bin, input logic [7:0] modulo,
                                         output logic bout);
    logic [7:0] av;
    logic [7:0] bv;
    logic [7:0] r;
    av = 8'(a[7:4]) * 8'h0a + 8'(a[3:0]);
    bv = 8'(b[7:4]) * 8'h0a + 8'(b[3:0]) + 8'(bin);
    if (av >= bv) begin
      r = av - bv;
      bout = 1'b0;
    end else begin
      r = av + modulo - bv;
      bout = 1'b1;
    end
    return {4'(r / 8'h0a), 4'(r % 8'h0a)};
  endfunction

  function automatic timecode_t tc_sub(input timecode_t a, input timecode_t b);
    timecode_t r;
    logic      br;
    r.frames  = bcd_sub(a.frames, b.frames, 1'b0, 8'h1e, br);
    r.seconds = bcd_sub(a.seconds, b.seconds, br, 8'h3c, br);
    r.minutes = bcd_sub(a.minutes, b.minutes, br, 8'h3c, br);
    r.hours   = bcd_sub(a.hours, b.hours, br, 8'h18, br);
    return r;
  endfunction

  assign vitc_less_off = tc_sub(vitc_time_in, offset_in);
  assign next_compare  = tc_sub(vitc_less_off, ltc_time_in); // (RULE8)

  // Counted sources share one structure
  assign counted_event = {events_in.dropout, events_in.validity | frames_bad,
                          events_in.time_seq, events_in.user_seq};
  assign counted_en    = {enable_in.dropout, enable_in.validity,
                          enable_in.time_seq, enable_in.user_seq}; // (RULE12)
  assign counted_thr[3] = limits_in.dropout_count;
  assign counted_thr[2] = limits_in.validity_count;
  assign counted_thr[1] = limits_in.time_seq_count;
  assign counted_thr[0] = limits_in.user_seq_count;

  assign frames_bad = frame_strobe_in &&
                      ((vitc_active_in ? vitc_time_in.frames : ltc_time_in.frames)
                       > FRAMES_MAX_BCD); // (RULE17)

  for (genvar i = 0; i < NUM_COUNTED; i++) begin : g_count
    threshold_counter u_cnt (
      .ref_clk_in   (ref_clk_in),
      .rst_in       (rst_in),
      .event_in     (counted_event[i]),
      .clear_in     (alarm_clear_key_in),
      .threshold_in (counted_thr[i]),
      .exceeded_out (exceeded[i])
    ); // (RULE16) (RULE18) (RULE19)
  end

  // Trigger vector, index order matches source code order
  always_comb begin
    trig    = '0;
    trig[1] = enable_in.ltc_phase && (ltc_phase_bits_in > limits_in.ltc_phase_bits); // (RULE13)
    trig[2] = enable_in.colour_phase &&
              (code_colour_field_in != ref_colour_field_in); // (RULE14)
    trig[3] = enable_in.ltc_vs_vitc && both_assigned_in &&
              (vitc_less_off != ltc_time_in); // (RULE15)
    trig[4] = counted_en[3] && exceeded[3];
    trig[5] = counted_en[2] && exceeded[2];
    trig[6] = counted_en[1] && exceeded[1];
    trig[7] = counted_en[0] && exceeded[0];
    trig[8] = enable_in.ltc_level && ((ltc_level_in < limits_in.level_min) ||
                                      (ltc_level_in > limits_in.level_max)); // (RULE20)
  end

  // Highest index wins when several fire together
  always_comb begin
    next_src = SRC_NONE;
    for (int k = 1; k < 9; k++) begin
      if (trig[k]) begin
        next_src = alarm_src_t'(k);
      end
    end
  end

  // Latch: a trigger in the clear cycle survives the clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      latched        <= 1'b0;
      last_alarm_out <= SRC_NONE;
    end else if (next_src != SRC_NONE) begin
      latched        <= 1'b1; // (RULE22)
      last_alarm_out <= next_src; // (RULE3)
    end else if (alarm_clear_key_in) begin
      latched        <= 1'b0; // (RULE4)
      last_alarm_out <= SRC_NONE;
    end
  end

  assign alarm_active_out = latched; // (RULE2)

  // Beeper cadence
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      beep_cnt   <= '0;
      beep_phase <= 1'b0;
    end else if (!latched) begin
      beep_cnt   <= '0;
      beep_phase <= 1'b0;
    end else if (beep_cnt == BEEP_CNT_W'(BEEP_HALF - 1)) begin
      beep_cnt   <= '0;
      beep_phase <= ~beep_phase; // (RULE1)
    end else begin
      beep_cnt <= beep_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      beeper_out <= 1'b0;
    end else begin
      beeper_out <= audible_en_in && latched && !beep_phase; // (RULE1)
    end
  end

  // Overlay values
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      colour_index_out <= 4'h0;
      compare_out      <= '0;
      flags_out        <= '0;
      code_errors_out  <= 3'h0;
    end else begin
      // Index 1-based; NTSC folds into four fields
      colour_index_out <= pal_in ? 4'(code_colour_field_in) + 4'h1
                                 : 4'(code_colour_field_in[1:0]) + 4'h1; // (RULE7)
      if (both_assigned_in) begin
        compare_out <= next_compare; // (RULE8)
      end
      flags_out       <= flags_in; // (RULE9)
      code_errors_out <= {hw_error_in, events_in.validity | frames_bad,
                          events_in.time_seq | events_in.user_seq}; // (RULE11)
    end
  end

  assign flag_parity_shown_out = !vitc_active_in; // (RULE10)
  assign flag_field_shown_out  = vitc_active_in; // (RULE10)

  // Last good time is the last frame read with no hardware error and frames in range
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_good  <= '0;
      prev_vitc  <= 1'b0;
      prev_learn <= 1'b0;
    end else begin
      if (frame_strobe_in && !hw_error_in && !frames_bad) begin
        last_good <= vitc_active_in ? vitc_time_in : ltc_time_in;
      end
      prev_vitc  <= vitc_active_in;
      prev_learn <= learn_in;
    end
  end

  // Log record holds until taken; new events while busy are dropped
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      log_valid_out  <= 1'b0;
      log_record_out <= '0;
    end else if (log_valid_out && !log_ready_in) begin
      log_valid_out <= 1'b1;
    end else if (learn_in && !prev_learn) begin
      log_valid_out  <= 1'b1; // (RULE6)
      log_record_out <= '{kind: LOG_LEARN, source: SRC_NONE,
                          vitc_active: vitc_active_in, last_good: last_good};
    end else if (serial_monitor_en_in && next_src != SRC_NONE &&
                 (!latched || next_src != last_alarm_out)) begin
      log_valid_out  <= 1'b1; // (RULE5)
      log_record_out <= '{kind: LOG_ALARM, source: next_src,
                          vitc_active: vitc_active_in, last_good: last_good};
    end else if (serial_monitor_en_in && vitc_active_in != prev_vitc) begin
      log_valid_out  <= 1'b1; // (RULE5)
      log_record_out <= '{kind: LOG_READER_CHANGE, source: SRC_NONE,
                          vitc_active: vitc_active_in, last_good: last_good};
    end else begin
      log_valid_out <= 1'b0;
    end
  end

endmodule

// File: verification/timecode_alarm_monitor_assertions.sv
`timescale 1ns/100ps
module timecode_alarm_monitor_assertions
  import tc_alarm_pkg::*;
(
  // Clock and reset
  input wire logic                        ref_clk_in,
  input wire logic                        rst_in,
  // Watched inputs
  input wire logic                        vitc_active_in,
  input wire logic [7:0]                  ltc_phase_bits_in,
  input wire logic [2:0]                  code_colour_field_in,
  input wire logic [2:0]                  ref_colour_field_in,
  input wire logic [7:0]                  ltc_level_in,
  input wire tc_alarm_pkg::alarm_enable_t enable_in,
  input wire tc_alarm_pkg::alarm_limits_t limits_in,
  input wire logic                        alarm_clear_key_in,
  // Watched outputs
  input wire logic                        beeper_out,
  input wire logic                        alarm_active_out,
  input wire tc_alarm_pkg::alarm_src_t    last_alarm_out,
  input wire logic                        flag_parity_shown_out,
  input wire logic                        flag_field_shown_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  hold_latch_a: assert property (alarm_active_out && !alarm_clear_key_in |=> alarm_active_out)
    else $error("alarm latch dropped without clear");
  clear_all_a: assert property (alarm_clear_key_in && enable_in == '0 |=> !alarm_active_out && last_alarm_out == SRC_NONE)
    else $error("alarm clear left state behind");
  // Beeper lags the latch by one cycle, hence two quiet cycles
  quiet_beep_a: assert property (!alarm_active_out [*2] |-> !beeper_out)
    else $error("beeper sounding without alarm");
  src_pair_a: assert property ((last_alarm_out == SRC_NONE) == !alarm_active_out)
    else $error("last alarm id out of step with latch");
  level_trig_a: assert property (enable_in.ltc_level && (ltc_level_in < limits_in.level_min || ltc_level_in > limits_in.level_max) |=> alarm_active_out)
    else $error("level alarm missed");
  phase_trig_a: assert property (enable_in.ltc_phase && ltc_phase_bits_in > limits_in.ltc_phase_bits |=> alarm_active_out)
    else $error("phase alarm missed");
  colour_trig_a: assert property (enable_in.colour_phase && code_colour_field_in != ref_colour_field_in |=> alarm_active_out)
    else $error("colour phase alarm missed");
  no_enable_a: assert property (!alarm_active_out && enable_in == '0 |=> !alarm_active_out)
    else $error("alarm raised with all sources off");
  shown_sel_a: assert property (flag_parity_shown_out == !vitc_active_in && flag_field_shown_out == vitc_active_in)
    else $error("flag slot shown for wrong reader");
endmodule

bind timecode_alarm_monitor timecode_alarm_monitor_assertions timecode_alarm_monitor_assertions_i (.*);

// File: verification/reader_model.sv
`timescale 1ns/100ps
module reader_model
  import tc_alarm_pkg::*;
(
  // Clock
  input  wire logic                 ref_clk_in,
  // Reader outputs
  output tc_alarm_pkg::reader_events_t events_out,
  output logic                      frame_strobe_out,
  output tc_alarm_pkg::timecode_t   ltc_time_out
);
  import tc_alarm_pkg::*;
  initial begin
    events_out = '0;
    frame_strobe_out = 1'b0;
    ltc_time_out = '0;
  end
  // One cycle high per event, so each pulse counts exactly once
  task automatic pulse(input reader_events_t ev);
    @(negedge ref_clk_in) events_out = ev;
    @(negedge ref_clk_in) events_out = '0;
  endtask
  task automatic frame(input timecode_t t);
    @(negedge ref_clk_in);
    ltc_time_out = t;
    frame_strobe_out = 1'b1;
    @(negedge ref_clk_in) frame_strobe_out = 1'b0;
  endtask
endmodule

// File: verification/timecode_alarm_monitor_bench.sv
`timescale 1ns/100ps
module timecode_alarm_monitor_bench;
  import tc_alarm_pkg::*;
  logic           ref_clk_in, rst_in, both_assigned_in, vitc_active_in, frame_strobe_in;
  logic           hw_error_in, pal_in, audible_en_in, serial_monitor_en_in, learn_in;
  logic           alarm_clear_key_in, log_ready_in, beeper_out, alarm_active_out, prev;
  logic           flag_parity_shown_out, flag_field_shown_out, log_valid_out;
  logic [7:0]     ltc_phase_bits_in, ltc_level_in;
  logic [2:0]     code_colour_field_in, ref_colour_field_in, code_errors_out;
  logic [3:0]     colour_index_out;
  timecode_t      ltc_time_in, vitc_time_in, offset_in, compare_out;
  code_flags_t    flags_in, flags_out;
  reader_events_t events_in;
  alarm_enable_t  enable_in;
  alarm_limits_t  limits_in;
  alarm_src_t     last_alarm_out;
  log_record_t    log_record_out;
  alarm_src_t     exp_q[$];
  int             n_mismatch, n_checks, seed, k, i, ones;
  logic [7:0]     lv[4] = '{8'h00, 8'h01, 8'h1e, 8'h1f};
  bit             lf[4] = '{1, 0, 0, 1};
  alarm_src_t     ssrc[2] = '{SRC_TIME_SEQ, SRC_USER_SEQ};

  timecode_alarm_monitor #(.BEEP_HALF(4)) timecode_alarm_monitor_i (.*);
  reader_model reader_model_i (.ref_clk_in, .events_out(events_in),
    .frame_strobe_out(frame_strobe_in), .ltc_time_out(ltc_time_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Expected source is queued after the cause is applied, before the latch rises; the monitor compares it
  task automatic outcome(input bit fire, input alarm_src_t src);
    if (fire) begin
      exp_q.push_back(src);
      k = 0;
      while (alarm_active_out !== 1'b1 && k < 10) begin
        cyc(1);
        k++;
      end
      if (k == 10) begin
        chk("alarm wait", 1, 0);
        report_and_stop();
      end
      cyc(1);
    end else begin
      cyc(4);
      chk("no alarm", 0, alarm_active_out);
    end
  endtask
  task automatic clear_all;
    enable_in = '0;
    alarm_clear_key_in = 1'b1;
    cyc(1);
    alarm_clear_key_in = 1'b0;
    cyc(2);
    chk("active", 0, alarm_active_out);
    chk("last", SRC_NONE, last_alarm_out);
    chk("beeper", 0, beeper_out);
  endtask

  always @(negedge ref_clk_in) begin
    if (alarm_active_out === 1'b1 && prev !== 1'b1) begin
      if (exp_q.size() == 0)
        chk("unexpected alarm", 0, 1);
      else
        chk("last alarm", exp_q.pop_front(), last_alarm_out);
    end
    prev = alarm_active_out;
  end

  initial begin
    seed = 27643;
    rst_in = 1'b1;
    {both_assigned_in, vitc_active_in, hw_error_in, pal_in, learn_in} = '0;
    {alarm_clear_key_in, log_ready_in, ltc_phase_bits_in, flags_in} = '0;
    {code_colour_field_in, ref_colour_field_in, vitc_time_in, offset_in} = '0;
    {audible_en_in, serial_monitor_en_in} = 2'b11;
    enable_in = '0;
    ltc_level_in = 8'h0a;
    limits_in = '{DEF_PHASE_BITS, DEF_COUNT, DEF_COUNT, DEF_COUNT, DEF_COUNT,
                  DEF_LEVEL_MIN, DEF_LEVEL_MAX};
    cyc(4);
    rst_in = 1'b0;
    chk("reset last", SRC_NONE, last_alarm_out);
    enable_in.dropout = 1'b1;
    reader_model_i.pulse(4'b1000);
    outcome(0, SRC_NONE);
    reader_model_i.pulse(4'b1000);
    outcome(1, SRC_DROPOUT);
    chk("log held", 1, log_valid_out);
    chk("log source", SRC_DROPOUT, log_record_out.source);
    chk("log kind", LOG_ALARM, log_record_out.kind);
    log_ready_in = 1'b1;
    ones = 0;
    // Four on, four off: any sixteen cycles hold eight on
    repeat (16) begin
      cyc(1);
      ones += (beeper_out === 1'b1);
    end
    chk("beeper on cycles", 8, ones);
    audible_en_in = 1'b0;
    ones = 0;
    repeat (8) begin
      cyc(1);
      ones += (beeper_out !== 1'b0);
    end
    chk("beeper muted", 0, ones);
    audible_en_in = 1'b1;
    enable_in.dropout = 1'b0;
    reader_model_i.pulse(4'b1000);
    cyc(2);
    chk("still latched", 1, alarm_active_out);
    clear_all();
    enable_in.dropout = 1'b1;
    reader_model_i.pulse(4'b1000);
    outcome(0, SRC_NONE);
    clear_all();
    for (i = 0; i < 4; i++) begin
      enable_in.ltc_level = 1'b1;
      ltc_level_in = lv[i];
      outcome(lf[i], SRC_LTC_LEVEL);
      ltc_level_in = 8'h0a;
      cyc(3);
      chk("held after cause", lf[i], alarm_active_out);
      clear_all();
    end
    repeat (6) begin
      ltc_phase_bits_in = 8'($random(seed) & 3);
      enable_in.ltc_phase = 1'b1;
      outcome(ltc_phase_bits_in > DEF_PHASE_BITS, SRC_LTC_PHASE);
      ltc_phase_bits_in = 8'h00;
      clear_all();
    end
    {pal_in, code_colour_field_in, ref_colour_field_in} = {1'b1, 3'h7, 3'h7};
    enable_in.colour_phase = 1'b1;
    outcome(0, SRC_NONE);
    chk("pal index", 4'h8, colour_index_out);
    code_colour_field_in = 3'($random(seed));
    ref_colour_field_in = code_colour_field_in + 3'h1;
    outcome(1, SRC_COLOUR_PHASE);
    chk("pal index", 4'(code_colour_field_in) + 4'h1, colour_index_out);
    {pal_in, code_colour_field_in, ref_colour_field_in} = {1'b0, 3'h6, 3'h6};
    cyc(2);
    chk("ntsc index", 4'h3, colour_index_out);
    clear_all();
    {both_assigned_in, vitc_time_in, offset_in} = {1'b1, 32'h01000012, 32'h00000002};
    reader_model_i.frame(32'h01000010);
    enable_in.ltc_vs_vitc = 1'b1;
    outcome(0, SRC_NONE);
    chk("compare zero", 32'h0, compare_out);
    offset_in = 32'h00000021;
    outcome(1, SRC_LTC_VS_VITC);
    chk("compare wrap", 32'h23595911, compare_out);
    clear_all();
    both_assigned_in = 1'b0;
    enable_in.validity = 1'b1;
    reader_model_i.frame(32'h01000030);
    reader_model_i.frame(32'h01000045);
    outcome(0, SRC_NONE);
    reader_model_i.frame(32'h01000046);
    outcome(1, SRC_VALIDITY);
    clear_all();
    limits_in.user_seq_count = 8'h02;
    for (i = 0; i < 2; i++) begin
      {serial_monitor_en_in, log_ready_in} = {i[0], 1'b0};
      enable_in = alarm_enable_t'(8'h04 >> i);
      repeat (2 + i) reader_model_i.pulse(reader_events_t'(4'h2 >> i));
      outcome(1, ssrc[i]);
      chk("log monitor gate", i[0], log_valid_out);
      clear_all();
    end
    {log_ready_in, learn_in} = 2'b11;
    cyc(1);
    chk("learn log kind", LOG_LEARN, log_record_out.kind);
    chk("learn log held", 1, log_valid_out);
    learn_in = 1'b0;
    flags_in = code_flags_t'($random(seed));
    {vitc_active_in, hw_error_in} = 2'b11;
    cyc(2);
    chk("flags", flags_in, flags_out);
    chk("hw error", 1, code_errors_out[2]);
    chk("field shown", 1, flag_field_shown_out);
    vitc_active_in = 1'b0;
    cyc(1);
    chk("parity shown", 1, flag_parity_shown_out);
    report_and_stop();
  end
endmodule
